// [src/smvs_defines.svh]
`ifndef SMVS_DEFINES_SVH
`define SMVS_DEFINES_SVH
// Overview of operation
// - Start register low bits launch a vector
// - Vector number minus one selects slot
// - Zero-clock vector runs only macro moves
// - State macro emits pre-count pulses, pattern TMS
// - Clearing setup bit 3 releases test reset
// - Type 10 is shift with capture
// - Pre-count 3 drives pattern bits 4-6
// - Shift holds loop bit, data on TDI
// - Last shifted bit drives mode-select high
// - Post-count mode-select values follow the shift
// - Compare needs slot bit 20; with slot bit 21 set, only where mask bit is zero
// - DR macro: capture, shift, exit, update, idle
// - Macro word field layout: type, counts, pattern
// - Setup bit 2 resets sequencer logic

// Register byte offsets
`define SMVS_OFS_START 8'h00
`define SMVS_OFS_SETUP 8'h04
`define SMVS_OFS_CLKDIV 8'h08
`define SMVS_OFS_STATUS 8'h0c
`define SMVS_OFS_EXPECT 8'h10
`define SMVS_OFS_MASK 8'h14
`define SMVS_OFS_DATA 8'h18
`define SMVS_OFS_CAPTURE 8'h1c
`define SMVS_PAGE_SLOT 3'b001
`define SMVS_PAGE_MACRO 3'b010

// Macro word fields
`define SMVS_MAC_TYPE_HI 17
`define SMVS_MAC_TYPE_LO 16
`define SMVS_MAC_PRE_HI 26
`define SMVS_MAC_PRE_LO 24
`define SMVS_MAC_POST_HI 22
`define SMVS_MAC_POST_LO 20
`define SMVS_MAC_LOOP 7
`define SMVS_MAC_PPAT_LO 4'd8
`define SMVS_MAC_PAT_LO 4'd2
`define SMVS_MAC_PAT_HI 4'd6
`define SMVS_MAC_PAT_END 4'd7

// Vector slot word fields
`define SMVS_SLOT_CLK_HI 15
`define SMVS_SLOT_CLK_LO 0
`define SMVS_SLOT_MAC_HI 18
`define SMVS_SLOT_MAC_LO 16
`define SMVS_SLOT_CMP 20
`define SMVS_SLOT_MSK 21

// Setup bits and reset values
`define SMVS_SETUP_SMRST 2
`define SMVS_SETUP_TRST 3
`define SMVS_SETUP_RST 8'h08
`define SMVS_CLKDIV_RST 16'h0010
`define SMVS_HALF_MIN 16'h0002
`define SMVS_WORD_BITS 6'h20

`endif

// [src/smvs_pkg.sv]
`default_nettype none
`include "smvs_defines.svh"
package smvs_pkg;
   // Sequencer states
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_PRE = 4'b0010,
      S_SHIFT = 4'b0100,
      S_POST = 4'b1000
   } smvs_state_t;

   // Macro types
   typedef enum logic [1:0] {
      MT_NONE = 2'b00,
      MT_DR = 2'b01,
      MT_IR = 2'b10,
      MT_STATE = 2'b11
   } smvs_mtype_t;

   // Whole sequencer state
   typedef struct packed {
      smvs_state_t st;
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
      logic tdo_s1;
      logic tdo_s2;
      logic fail;
      logic [15:0] div_cnt;
      logic [15:0] clkdiv;
      logic [15:0] pos;
      logic [15:0] errors;
      logic [2:0] cnt;
      logic [2:0] last_vec;
      logic [5:0] bits_left;
      logic [31:0] vec;
      logic [31:0] mac;
      logic [31:0] shreg;
      logic [31:0] capture;
      logic [31:0] exp_w;
      logic [31:0] mask_w;
      logic [31:0] prdata;
      logic [7:0] setup;
      logic [7:0][31:0] slots;
      logic [7:0][31:0] macros;
   } smvs_regs_t;
endpackage
`default_nettype wire

// [src/smvs_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
// Vector data FIFO; depth must be a power of two
module smvs_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
      logic [WIDTH-1:0] rdata;
   } smvs_fifo_t;

   smvs_fifo_t f_reg, f_next;
   logic push, pop;

   // Handshakes from the fill count
   assign in_ready_o = (f_reg.cnt != CW'(DEPTH));
   assign out_valid_o = (f_reg.cnt != '0);
   assign out_data_o = f_reg.rdata;
   assign push = in_valid_i & in_ready_o;
   assign pop = out_ready_i & out_valid_o;

   // Pointer, count and head register update
   always_comb begin
      f_next = f_reg;
      if (push) begin
         f_next.mem[f_reg.wp] = in_data_i;
         f_next.wp = f_reg.wp + 1'b1;
      end
      if (pop) begin
         f_next.rp = f_reg.rp + 1'b1;
      end
      if (push && !pop) begin
         f_next.cnt = f_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         f_next.cnt = f_reg.cnt - 1'b1;
      end
      // Head word bypasses memory when written into the read slot
      if (push && (f_reg.wp == f_next.rp)) begin
         f_next.rdata = in_data_i;
      end else begin
         f_next.rdata = f_reg.mem[f_next.rp];
      end
      if (flush_i) begin
         f_next.wp = '0;
         f_next.rp = '0;
         f_next.cnt = '0;
      end
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end
endmodule
`default_nettype wire

// [src/smvs_seq.sv]
`timescale 1ns/10ps
`default_nettype none
`include "smvs_defines.svh"
// Scan-master vector sequencer with APB register access
module smvs_seq #(
   parameter int FIFO_DEPTH = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic master_test_clock_out_o,
   output logic master_mode_select_out_o,
   output logic master_serial_test_out_o,
   output logic test_reset_n_o,
   input wire logic return_serial_in_i
);
   localparam smvs_pkg::smvs_regs_t RST_VAL = '{
      st: smvs_pkg::S_IDLE,
      clkdiv: `SMVS_CLKDIV_RST,
      setup: `SMVS_SETUP_RST,
      default: '0
   };

   smvs_pkg::smvs_regs_t r_reg, r_next;
   logic acc, wr, mapped, push, fifo_in_ready, fifo_out_valid, fifo_pop, fifo_flush;
   logic start_go, smrst, chk, last_bit;
   logic [31:0] fifo_data, rd_mux;
   logic [15:0] half, clocks;
   logic [2:0] pre_n, post_n, start_num;
   logic [1:0] mtype;

   // Mode-select bit of pre-shift pulse k
   function automatic logic pre_bit(input logic [31:0] m, input logic [2:0] n,
                                    input logic [2:0] k);
      logic [3:0] idx;
      idx = `SMVS_MAC_PAT_END - {1'b0, n} + {1'b0, k};
      if (idx >= `SMVS_MAC_PAT_LO && idx <= `SMVS_MAC_PAT_HI) begin
         pre_bit = m[idx];
      end else begin
         pre_bit = 1'b1;
      end
   endfunction

   // Mode-select bit of post-shift pulse k
   function automatic logic post_bit(input logic [31:0] m, input logic [2:0] k);
      logic [3:0] idx;
      idx = `SMVS_MAC_PPAT_LO + {1'b0, k};
      post_bit = m[idx];
   endfunction

   // Field extraction from the running vector and macro
   assign half = (r_reg.clkdiv < `SMVS_HALF_MIN) ? `SMVS_HALF_MIN : r_reg.clkdiv;
   assign clocks = r_reg.vec[`SMVS_SLOT_CLK_HI:`SMVS_SLOT_CLK_LO];
   assign mtype = r_reg.mac[`SMVS_MAC_TYPE_HI:`SMVS_MAC_TYPE_LO];
   assign pre_n = r_reg.mac[`SMVS_MAC_PRE_HI:`SMVS_MAC_PRE_LO];
   assign post_n = r_reg.mac[`SMVS_MAC_POST_HI:`SMVS_MAC_POST_LO];
   assign last_bit = (r_reg.pos == clocks - 16'h0001);

   // APB handshake; data pushes stall while the FIFO is full
   assign acc = psel_i & penable_i;
   assign pready_o = !(pwrite_i && (paddr_i == `SMVS_OFS_DATA) && !fifo_in_ready);
   assign wr = acc & pwrite_i & pready_o;
   assign pslverr_o = acc & !mapped;
   assign push = wr & (paddr_i == `SMVS_OFS_DATA);
   assign start_num = pwdata_i[2:0];
   assign start_go = wr && (paddr_i == `SMVS_OFS_START) && (start_num != 3'h0)
                     && (r_reg.st == smvs_pkg::S_IDLE);
   assign smrst = wr && (paddr_i == `SMVS_OFS_SETUP) && pwdata_i[`SMVS_SETUP_SMRST];
   assign chk = (r_reg.pos < 16'h0020) && r_reg.vec[`SMVS_SLOT_CMP]
                && !(r_reg.vec[`SMVS_SLOT_MSK] && r_reg.mask_w[r_reg.pos[4:0]]);

   // Read mux and address decode
   always_comb begin
      rd_mux = 32'h0000_0000;
      mapped = 1'b1;
      if (paddr_i[7:5] == `SMVS_PAGE_SLOT) begin
         rd_mux = r_reg.slots[paddr_i[4:2]];
      end else if (paddr_i[7:5] == `SMVS_PAGE_MACRO) begin
         rd_mux = r_reg.macros[paddr_i[4:2]];
      end else begin
         case (paddr_i)
            `SMVS_OFS_START: rd_mux = {23'h0, r_reg.st != smvs_pkg::S_IDLE, 5'h0, r_reg.last_vec};
            `SMVS_OFS_SETUP: rd_mux = {24'h0, r_reg.setup};
            `SMVS_OFS_CLKDIV: rd_mux = {16'h0, r_reg.clkdiv};
            `SMVS_OFS_STATUS: rd_mux = {r_reg.errors, 14'h0, r_reg.fail,
                                        r_reg.st != smvs_pkg::S_IDLE};
            `SMVS_OFS_EXPECT: rd_mux = r_reg.exp_w;
            `SMVS_OFS_MASK: rd_mux = r_reg.mask_w;
            `SMVS_OFS_DATA: rd_mux = 32'h0000_0000;
            `SMVS_OFS_CAPTURE: rd_mux = r_reg.capture;
            default: mapped = 1'b0;
         endcase
      end
   end

   // Next-state logic: registers, then sequencer, then soft reset
   always_comb begin
      logic go;
      go = 1'b0;
      r_next = r_reg;
      fifo_pop = 1'b0;
      fifo_flush = 1'b0;
      r_next.tdo_s1 = return_serial_in_i;
      r_next.tdo_s2 = r_reg.tdo_s1;
      if (psel_i && !penable_i && !pwrite_i) begin
         r_next.prdata = rd_mux;
      end
      if (wr) begin
         if (paddr_i[7:5] == `SMVS_PAGE_SLOT) begin
            r_next.slots[paddr_i[4:2]] = pwdata_i;
         end else if (paddr_i[7:5] == `SMVS_PAGE_MACRO) begin
            r_next.macros[paddr_i[4:2]] = pwdata_i;
         end else begin
            case (paddr_i)
               `SMVS_OFS_SETUP: r_next.setup = pwdata_i[7:0];
               `SMVS_OFS_CLKDIV: r_next.clkdiv = pwdata_i[15:0];
               `SMVS_OFS_EXPECT: r_next.exp_w = pwdata_i;
               `SMVS_OFS_MASK: r_next.mask_w = pwdata_i;
               `SMVS_OFS_STATUS: begin
                  if (pwdata_i[1]) begin
                     r_next.fail = 1'b0;
                     r_next.errors = 16'h0000;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // launch vector; slot is number minus one
      if (start_go) begin
         r_next.last_vec = start_num;
         r_next.vec = r_reg.slots[start_num - 3'h1];
         r_next.mac = r_reg.macros[r_reg.slots[start_num - 3'h1]
                                   [`SMVS_SLOT_MAC_HI:`SMVS_SLOT_MAC_LO]];
         r_next.st = smvs_pkg::S_PRE;
         r_next.cnt = 3'h0;
         r_next.pos = 16'h0000;
         r_next.bits_left = 6'h00;
         r_next.div_cnt = 16'h0000;
         r_next.tck = 1'b0;
      end
      // Sequencer: low phase sets up the pulse, high phase ends it
      if (r_reg.st != smvs_pkg::S_IDLE && !r_reg.tck) begin
         case (r_reg.st)
            smvs_pkg::S_PRE: begin
               if (r_reg.cnt == pre_n) begin
                  r_next.cnt = 3'h0;
                  // state macro or zero clocks skip the shift
                  if (mtype == smvs_pkg::MT_STATE) begin
                     r_next.st = smvs_pkg::S_IDLE;
                  end else if (clocks == 16'h0000) begin
                     r_next.st = smvs_pkg::S_POST;
                  end else begin
                     r_next.st = smvs_pkg::S_SHIFT;
                  end
               end else begin
                  r_next.tms = pre_bit(r_reg.mac, pre_n, r_reg.cnt);
                  go = 1'b1;
               end
            end
            smvs_pkg::S_SHIFT: begin
               if (r_reg.pos == clocks) begin
                  r_next.st = smvs_pkg::S_POST;
                  r_next.cnt = 3'h0;
               end else if (r_reg.bits_left == 6'h00) begin
                  // Wait for the next data word
                  if (fifo_out_valid) begin
                     fifo_pop = 1'b1;
                     r_next.shreg = fifo_data;
                     r_next.bits_left = `SMVS_WORD_BITS;
                  end
               end else begin
                  // loop bit on mode-select; high on last bit
                  r_next.tms = last_bit ? 1'b1 : r_reg.mac[`SMVS_MAC_LOOP];
                  r_next.tdi = r_reg.shreg[0];
                  go = 1'b1;
               end
            end
            smvs_pkg::S_POST: begin
               if (r_reg.cnt == post_n) begin
                  r_next.st = smvs_pkg::S_IDLE;
               end else begin
                  r_next.tms = post_bit(r_reg.mac, r_reg.cnt);
                  go = 1'b1;
               end
            end
            default: r_next.st = smvs_pkg::S_IDLE;
         endcase
         if (go) begin
            if (r_reg.div_cnt == half - 16'h0001) begin
               r_next.tck = 1'b1;
               r_next.div_cnt = 16'h0000;
            end else begin
               r_next.div_cnt = r_reg.div_cnt + 16'h0001;
            end
         end
      end else if (r_reg.st != smvs_pkg::S_IDLE) begin
         if (r_reg.div_cnt == half - 16'h0001) begin
            r_next.tck = 1'b0;
            r_next.div_cnt = 16'h0000;
            if (r_reg.st == smvs_pkg::S_SHIFT) begin
               r_next.capture = {r_reg.tdo_s2, r_reg.capture[31:1]};
               if (chk && (r_reg.tdo_s2 != r_reg.exp_w[r_reg.pos[4:0]])) begin
                  r_next.errors = r_reg.errors + 16'h0001;
                  r_next.fail = 1'b1;
               end
               r_next.pos = r_reg.pos + 16'h0001;
               r_next.shreg = {1'b0, r_reg.shreg[31:1]};
               r_next.bits_left = r_reg.bits_left - 6'h01;
            end else begin
               r_next.cnt = r_reg.cnt + 3'h1;
            end
         end else begin
            r_next.div_cnt = r_reg.div_cnt + 16'h0001;
         end
      end
      if (smrst) begin
         r_next.st = smvs_pkg::S_IDLE;
         r_next.tck = 1'b0;
         r_next.div_cnt = 16'h0000;
         r_next.errors = 16'h0000;
         r_next.fail = 1'b0;
         r_next.setup[`SMVS_SETUP_SMRST] = 1'b0;
         fifo_flush = 1'b1;
      end
      // test reset follows setup bit 3, active low
      r_next.trst_n = !r_next.setup[`SMVS_SETUP_TRST];
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         r_reg <= RST_VAL;
      end else begin
         r_reg <= r_next;
      end
   end

   // Vector data buffer
   smvs_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .flush_i(fifo_flush),
      .in_valid_i(push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(pwdata_i),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_data)
   );

   // Pin and bus outputs
   assign prdata_o = r_reg.prdata;
   assign master_test_clock_out_o = r_reg.tck;
   assign master_mode_select_out_o = r_reg.tms;
   assign master_serial_test_out_o = r_reg.tdi;
   assign test_reset_n_o = r_reg.trst_n;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_launch;
      start_go |=> (r_reg.st == smvs_pkg::S_PRE) ##1 (r_reg.st != smvs_pkg::S_IDLE || !smrst);
   endproperty
   a_launch: assert property (p_launch) else $error("vector did not launch");

   property p_slot;
      start_go |=> r_reg.vec == $past(r_reg.slots[start_num - 3'h1]);
   endproperty
   a_slot: assert property (p_slot) else $error("wrong slot selected");

   property p_noshift;
      (r_reg.st == smvs_pkg::S_SHIFT) |-> (clocks != 16'h0000 && mtype != smvs_pkg::MT_STATE);
   endproperty
   a_noshift: assert property (p_noshift) else $error("shift without clocks");

   property p_pre;
      ($rose(r_reg.tck) && r_reg.st == smvs_pkg::S_PRE)
         |-> r_reg.tms == pre_bit(r_reg.mac, pre_n, r_reg.cnt) && r_reg.cnt < pre_n;
   endproperty
   a_pre: assert property (p_pre) else $error("pre-shift mode-select wrong");

   property p_trst;
      (wr && paddr_i == `SMVS_OFS_SETUP && !pwdata_i[`SMVS_SETUP_TRST]) |=> test_reset_n_o;
   endproperty
   a_trst: assert property (p_trst) else $error("test reset not released");

   property p_shift;
      ($rose(r_reg.tck) && r_reg.st == smvs_pkg::S_SHIFT)
         |-> r_reg.tms == (last_bit ? 1'b1 : r_reg.mac[`SMVS_MAC_LOOP]);
   endproperty
   a_shift: assert property (p_shift) else $error("shift mode-select wrong");

   property p_post;
      ($rose(r_reg.tck) && r_reg.st == smvs_pkg::S_POST)
         |-> r_reg.tms == post_bit(r_reg.mac, r_reg.cnt) && r_reg.cnt < post_n;
   endproperty
   a_post: assert property (p_post) else $error("post-shift mode-select wrong");

   property p_mask;
      ($fell(r_next.tck) && r_reg.st == smvs_pkg::S_SHIFT && !chk && !smrst)
         |=> r_reg.errors == $past(r_reg.errors);
   endproperty
   a_mask: assert property (p_mask) else $error("masked bit counted");

   property p_smrst;
      smrst |=> (r_reg.st == smvs_pkg::S_IDLE && !r_reg.tck) [*2];
   endproperty
   a_smrst: assert property (p_smrst) else $error("soft reset ignored");
endmodule
`default_nettype wire

// [tb/smvs_tap_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Behavioural scan chain: one TAP with a fixed return pattern and a pin log
module smvs_tap_model #(
   parameter logic [31:0] RET = 32'h0000_00a5
) (
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   input wire logic trst_n_i,
   output logic tdo_o
);
   // Next state for mode-select 0 and 1, one nibble per state
   localparam logic [63:0] NXT0 = 64'h1bdd_bba1_4664_4311;
   localparam logic [63:0] NXT1 = 64'h2fef_cc02_8785_5920;
   logic [3:0] st = 4'h0;
   logic [4:0] idx = 5'h00;
   int n = 0;
   logic tms_log [0:2047];
   logic tdi_log [0:2047];

   initial tdo_o = 1'b0;

   // sixteen-state moves on rising test clock
   always @(posedge tck_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         st <= 4'h0;
      end else begin
         tms_log[n] <= tms_i;
         tdi_log[n] <= tdi_i;
         n <= n + 1;
         st <= tms_i ? NXT1[st*4 +: 4] : NXT0[st*4 +: 4];
      end
   end

   // return bit changes on falling edge, garbage outside shift states
   always @(negedge tck_i) begin
      if (st == 4'h4 || st == 4'hb) begin
         tdo_o <= RET[idx];
         idx <= idx + 5'h01;
      end else begin
         tdo_o <= ~tdo_o;
         idx <= 5'h00;
      end
   end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "smvs_defines.svh"
`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("BAD %0t got %0h expected %0h", $time, (got), (exp)); \
      end \
   end
module tb_top;
   localparam logic [31:0] MAC_RST = 32'h0503_007c;
   localparam logic [31:0] MAC_IDLE = 32'h0103_0000;
   localparam logic [31:0] MAC_IR = 32'h0322_0130;
   localparam logic [31:0] MAC_DR = 32'h0221_0120;
   logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic tck, tms, tdi, trst_n, tdo;
   int miscompares = 0;
   int cmp_count = 0;
   logic [31:0] dq [$];

   smvs_seq dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .master_test_clock_out_o(tck),
      .master_mode_select_out_o(tms), .master_serial_test_out_o(tdi),
      .test_reset_n_o(trst_n), .return_serial_in_i(tdo));
   smvs_tap_model tap (.tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo));

   // System clock, 20 ns
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic close_out;
      $display("Checks %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic to_fail;
      miscompares++;
      $display("BAD %0t wait limit reached", $time);
      close_out();
   endtask

   // One APB transfer, held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic err, output int w);
      w = 0;
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) begin
         w++;
         if (w > 3000) to_fail();
         @(posedge clk_i);
      end
      r = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      int w;
      apb(1'b1, a, d, r, e, w);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      int w;
      apb(1'b0, a, 32'h0, r, e, w);
   endtask

   task automatic launch(input logic [2:0] v, input logic [31:0] slot, output int n0);
      wr(8'h20 + {3'h0, v - 3'h1, 2'b00}, slot);
      n0 = tap.n;
      wr(`SMVS_OFS_START, {29'h0, v});
   endtask

   task automatic wait_idle;
      logic [31:0] s;
      s = 32'h1;
      for (int i = 0; i < 5000 && s[0] !== 1'b0; i++) rd(`SMVS_OFS_STATUS, s);
      if (s[0] !== 1'b0) to_fail();
   endtask

   // Pin log against the macro and slot fields
   task automatic check_pins(input logic [31:0] mac, input int clks, input int n0);
      int k;
      int pre;
      int post;
      logic sh;
      pre = int'(mac[26:24]);
      sh = (mac[17:16] != 2'b11);
      post = sh ? int'(mac[22:20]) : 0;
      for (int i = 0; i < pre; i++) begin
         `CHK(tap.tms_log[n0 + i], mac[7 - pre + i])
      end
      k = n0 + pre;
      for (int i = 0; i < clks && sh; i++) begin
         `CHK(tap.tms_log[k + i], (i == clks - 1) ? 1'b1 : mac[7])
         `CHK(tap.tdi_log[k + i], dq[i / 32][i % 32])
      end
      if (sh) k = k + clks;
      for (int i = 0; i < post; i++) begin
         `CHK(tap.tms_log[k + i], mac[8 + i])
      end
      `CHK(tap.n, k + post)
   endtask

   task automatic t_reset;
      logic [31:0] r;
      logic e;
      int w;
      `CHK(trst_n, 1'b0)
      `CHK(tck, 1'b0)
      rd(`SMVS_OFS_SETUP, r);
      `CHK(r[7:0], `SMVS_SETUP_RST)
      apb(1'b0, 8'h60, 32'h0, r, e, w);
      `CHK(e, 1'b1)
      `CHK(r, 32'h0000_0000)
   endtask

   task automatic t_setup;
      logic [31:0] r;
      wr(`SMVS_OFS_SETUP, 32'h0000_000c);
      rd(`SMVS_OFS_SETUP, r);
      `CHK(r[7:0], 8'h08)
      wr(`SMVS_OFS_SETUP, 32'h0000_0000);
      `CHK(trst_n, 1'b1)
      wr(`SMVS_OFS_CLKDIV, 32'h0000_0004);
      wr(8'h50, MAC_RST);
      wr(8'h4c, MAC_IDLE);
      wr(8'h48, MAC_IR);
      wr(8'h44, MAC_DR);
   endtask

   task automatic t_abort;
      int n0;
      logic [31:0] s;
      launch(3'h1, 32'h0001_0008, n0);
      repeat (60) @(posedge clk_i);
      `CHK(tap.n, n0 + 2)
      // A start while busy is ignored
      wr(`SMVS_OFS_START, 32'h0000_0002);
      rd(`SMVS_OFS_START, s);
      `CHK(s[8], 1'b1)
      `CHK(s[2:0], 3'h1)
      wr(`SMVS_OFS_SETUP, 32'h0000_0004);
      rd(`SMVS_OFS_STATUS, s);
      `CHK(s[0], 1'b0)
      `CHK(tck, 1'b0)
   endtask

   task automatic t_state;
      int n0;
      launch(3'h1, 32'h0004_0000, n0);
      wait_idle();
      check_pins(MAC_RST, 0, n0);
      `CHK(tap.st, 4'h0)
      launch(3'h1, 32'h0003_0000, n0);
      wait_idle();
      check_pins(MAC_IDLE, 0, n0);
      `CHK(tap.st, 4'h1)
   endtask

   task automatic t_fifo;
      int n0;
      int w;
      logic e;
      logic [31:0] r;
      logic [31:0] d;
      dq = {};
      launch(3'h4, 32'h0001_0440, n0);
      repeat (60) @(posedge clk_i);
      `CHK(tap.n, n0 + 2)
      `CHK(tck, 1'b0)
      for (int i = 0; i < 34; i++) begin
         d = {4{i[7:0]}} ^ 32'hc3a5_5a3c;
         dq.push_back(d);
         apb(1'b1, `SMVS_OFS_DATA, d, r, e, w);
      end
      `CHK(w > 0, 1'b1)
      wait_idle();
      check_pins(MAC_DR, 1088, n0);
      `CHK(tap.st, 4'h1)
   endtask

   task automatic t_shift_ir;
      int n0;
      logic [31:0] s;
      wr(`SMVS_OFS_EXPECT, 32'h0000_004c);
      wr(`SMVS_OFS_MASK, 32'hffff_ff03);
      dq = {32'h0000_0009};
      wr(`SMVS_OFS_DATA, 32'h0000_0009);
      launch(3'h3, 32'h0032_0008, n0);
      wait_idle();
      check_pins(MAC_IR, 8, n0);
      `CHK(tap.st, 4'h1)
      rd(`SMVS_OFS_STATUS, s);
      `CHK(s[31:16], 16'h0001)
      `CHK(s[1], 1'b1)
      wr(`SMVS_OFS_STATUS, 32'h0000_0002);
      rd(`SMVS_OFS_STATUS, s);
      `CHK(s[31:16], 16'h0000)
      // Capture holds the chain's return bits, one behind the shift
      rd(`SMVS_OFS_CAPTURE, s);
      `CHK(s[31:25], tap.RET[6:0])
      rd(`SMVS_OFS_START, s);
      `CHK(s[2:0], 3'h3)
      // Shift macro with zero clocks: pre and post moves only
      launch(3'h2, 32'h0001_0000, n0);
      wait_idle();
      check_pins(MAC_DR, 0, n0);
      `CHK(tap.st, 4'h6)
   endtask

   // Main sequence
   initial begin
      rst_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_setup();
      t_abort();
      t_state();
      t_fifo();
      t_shift_ir();
      close_out();
   end
endmodule
`default_nettype wire
